// File: common/pmi_pkg.sv
package pmi_pkg;
	// Slow-clock enable divider: 125 MHz down to about 32 kHz
	localparam int CLK_HZ = 125000000;
	localparam int SLOW_HZ = 32768;
	localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam int SLOW_DIV_W = 12;
	// Suspend debounce: stable slow-clock samples before a level is taken
	localparam int DEB_SAMPLES = 4;
	localparam int DEB_W = 4;
	// Register map, one aligned word each
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	// Config register field positions
	localparam int CFG_ACT_EN = 0;
	localparam int CFG_VPORT_SEL = 1;
	localparam int CFG_ACT_SBY_SEL = 2;
	localparam int CFG_BL_SUSP_SEL = 3;
	localparam int CFG_SBY_TMR_RST_EN = 4;
	localparam int CFG_BL_TMR_RST_EN = 5;
	localparam int CFG_W = 6;
	localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
	// Status register field positions
	localparam int ST_STRAP = 0;
	localparam int ST_STANDBY = 1;
	localparam int ST_SUSPEND = 2;
	localparam int ST_BL_OFF = 3;
	localparam int ST_ACT_IN = 4;
	localparam int ST_SUSP_DEB = 5;
endpackage : pmi_pkg

// File: design/pmi_pins.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Shared pin active only strap0, enable1, vport0
// - Select 1: rising edge is activity
// - Activity restarts standby timer when enabled
// - Activity restarts backlight timer when enabled
// - Select 0: going high requests standby
// - Backlight/suspend pin active only with strap0
// - Select 1: high level switches backlight off
// - Select 0: debounced high requests suspend
// - Standby status low while in standby
// - Suspend status low while in suspend
module pmi_pins import pmi_pkg::*; #(
	parameter int DEB_COUNT = DEB_SAMPLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Shared pins and strap
	input wire logic act_sby_pin_i,
	input wire logic bl_susp_pin_i,
	input wire logic feature_connector_strap_bit_i,
	// Mode state from the power sequencer
	input wire logic in_standby_i,
	input wire logic in_suspend_i,
	// Requests to timers and sequencer
	output logic standby_timer_restart_o,
	output logic backlight_timer_restart_o,
	output logic standby_request_o,
	output logic backlight_off_o,
	output logic suspend_request_o,
	// Status pins
	output logic standby_status_n_o,
	output logic suspend_status_n_o
);
	initial begin
		if (DEB_COUNT < 1 || DEB_COUNT >= (1 << DEB_W)) $error("DEB_COUNT out of range");
	end

	// All state of the block
	typedef struct packed {
		logic [CFG_W-1:0] cfg; // Software configuration
		logic strap; // Strap caught after reset
		logic strap_done; // Strap captured once
		logic [SLOW_DIV_W-1:0] div; // Slow enable divider
		logic act_prev; // Last shared pin sample
		logic sby_prev; // Last standby request level
		logic [DEB_W-1:0] deb_cnt; // Stable sample count
		logic susp_deb; // Debounced suspend level
		logic sby_tmr_rst; // Timer restart pulses
		logic bl_tmr_rst;
		logic sby_req; // Standby start pulse
		logic bl_off; // Backlight off level
		logic susp_req; // Suspend request level
		logic sby_st_n; // Status pins
		logic susp_st_n;
		logic [31:0] rdata; // Read data
	} pmi_state_t;

	pmi_state_t st;
	pmi_state_t next_st;
	logic slow_en; // One-cycle slow clock enable
	logic pin1_on; // Activity/standby pin usable
	logic pin2_on; // Backlight/suspend pin usable
	logic act_rise; // Rising edge on shared pin
	logic apb_acc; // APB access phase
	logic [31:0] status_word; // Status readback

	// Combinational next state
	always_comb begin
		next_st = st;
		slow_en = (st.div == SLOW_DIV_W'(SLOW_DIV - 1));
		pin1_on = !st.strap && st.cfg[CFG_ACT_EN] && !st.cfg[CFG_VPORT_SEL];
		pin2_on = !st.strap;
		act_rise = act_sby_pin_i && !st.act_prev;
		apb_acc = psel_i && penable_i;
		status_word = 32'h0;
		status_word[ST_STRAP] = st.strap;
		status_word[ST_STANDBY] = in_standby_i;
		status_word[ST_SUSPEND] = in_suspend_i;
		status_word[ST_BL_OFF] = st.bl_off;
		status_word[ST_ACT_IN] = act_sby_pin_i;
		status_word[ST_SUSP_DEB] = st.susp_deb;
		// Strap is taken once after reset release
		if (!st.strap_done) begin
			next_st.strap = feature_connector_strap_bit_i;
			next_st.strap_done = 1'b1;
		end
		// Divider for the slow enable
		next_st.div = slow_en ? '0 : st.div + 1'b1;
		// Edge history
		next_st.act_prev = act_sby_pin_i;
		// Activity role: low level or steady high restarts nothing
		next_st.sby_tmr_rst = pin1_on && st.cfg[CFG_ACT_SBY_SEL] && act_rise
			&& st.cfg[CFG_SBY_TMR_RST_EN];
		next_st.bl_tmr_rst = pin1_on && st.cfg[CFG_ACT_SBY_SEL] && act_rise
			&& st.cfg[CFG_BL_TMR_RST_EN];
		// Standby role: only a true low-to-high pin edge starts power-down, so enabling
		// the role while the pin already sits high does not fire a spurious request
		next_st.sby_prev = act_sby_pin_i;
		next_st.sby_req = pin1_on && !st.cfg[CFG_ACT_SBY_SEL] && act_sby_pin_i && !st.sby_prev;
		// Backlight role, gated by the pin-sharing strap condition
		next_st.bl_off = pin2_on && st.cfg[CFG_BL_SUSP_SEL] && bl_susp_pin_i;
		// Suspend debouncer sampled on slow enable
		if (slow_en) begin
			if (bl_susp_pin_i == st.susp_deb) begin
				next_st.deb_cnt = '0;
			end else if (st.deb_cnt == DEB_W'(DEB_COUNT - 1)) begin
				next_st.deb_cnt = '0;
				next_st.susp_deb = bl_susp_pin_i;
			end else begin
				next_st.deb_cnt = st.deb_cnt + 1'b1;
			end
		end
		next_st.susp_req = pin2_on && !st.cfg[CFG_BL_SUSP_SEL] && st.susp_deb;
		// Status pins follow mode
		next_st.sby_st_n = !in_standby_i;
		next_st.susp_st_n = !in_suspend_i;
		// APB write and read
		if (apb_acc && pwrite_i && paddr_i == OFS_CONFIG) begin
			next_st.cfg = pwdata_i[CFG_W-1:0];
		end
		if (psel_i && !penable_i && !pwrite_i) begin
			unique case (paddr_i)
				OFS_CONFIG: next_st.rdata = {{(32-CFG_W){1'b0}}, st.cfg};
				OFS_STATUS: next_st.rdata = status_word;
				default: next_st.rdata = 32'h0;
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st <= '{cfg: CFG_RESET, sby_st_n: 1'b1, susp_st_n: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// APB answers in the first access cycle
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && paddr_i != OFS_CONFIG && paddr_i != OFS_STATUS;
	assign prdata_o = st.rdata;
	// Outputs from flip-flops
	assign standby_timer_restart_o = st.sby_tmr_rst;
	assign backlight_timer_restart_o = st.bl_tmr_rst;
	assign standby_request_o = st.sby_req;
	assign backlight_off_o = st.bl_off;
	assign suspend_request_o = st.susp_req;
	assign standby_status_n_o = st.sby_st_n;
	assign suspend_status_n_o = st.susp_st_n;
endmodule : pmi_pins

// File: sim/pmi_pins_checker.sv
`timescale 1ns/10ps
module pmi_pins_checker (
	// Watched ports
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic pslverr_o,
	input wire logic act_sby_pin_i,
	input wire logic in_standby_i,
	input wire logic in_suspend_i,
	input wire logic standby_timer_restart_o,
	input wire logic backlight_timer_restart_o,
	input wire logic standby_request_o,
	input wire logic standby_status_n_o,
	input wire logic suspend_status_n_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	AST_ERR: assert property (psel_i && penable_i && paddr_i > 8'h04 |-> pslverr_o) else $error("no slave error");
	AST_SBY_ST: assert property ($past(rst_n_i) |-> standby_status_n_o == !$past(in_standby_i))
		else $error("standby status wrong");
	AST_SUS_ST: assert property ($past(rst_n_i) |-> suspend_status_n_o == !$past(in_suspend_i))
		else $error("suspend status wrong");
	AST_SR_SRC: assert property (standby_timer_restart_o |-> $past(act_sby_pin_i) && !$past(act_sby_pin_i, 2))
		else $error("restart without pin");
	AST_SR_ONE: assert property (standby_timer_restart_o |=> !standby_timer_restart_o) else $error("long pulse");
	AST_BR_ONE: assert property (backlight_timer_restart_o |=> !backlight_timer_restart_o) else $error("long pulse");
	AST_SQ_ONE: assert property (standby_request_o |=> !standby_request_o) else $error("long request");
	AST_SQ_SRC: assert property (standby_request_o |-> $past(act_sby_pin_i) && !$past(act_sby_pin_i, 2))
		else $error("request without pin");
endmodule : pmi_pins_checker
bind pmi_pins pmi_pins_checker chk (.*);

// File: sim/pmi_sys_model.sv
`timescale 1ns/10ps
module pmi_sys_model (
	// Clock and bench requests
	input wire logic mclk_i,
	input wire logic act_req_i,
	input wire logic bl_req_i,
	// Pins driven into the block
	output logic act_pin_o,
	output logic bl_pin_o
);
	// Pins follow requests one cycle late; idle level is low
	always_ff @(posedge mclk_i) begin
		act_pin_o <= act_req_i;
		bl_pin_o <= bl_req_i;
	end
endmodule : pmi_sys_model

// File: sim/tb_pmi_pins.sv
`timescale 1ns/10ps
module tb_pmi_pins;
	logic mclk_i = 0, rst_n_i = 0, ps = 0, pe = 0, pw = 0, ar = 0, br = 0, sb = 0, su = 0, rdy, er, re, ap, bp;
	logic srr, brr, sq, blo, suq, sbn, sun;
	logic [7:0] pa = 0;
	logic [31:0] wd = 0, prd, rd;
	int error_cnt = 0, checks = 0, sr_n = 0, br_n = 0, sq_n = 0, i;
	initial forever #4 mclk_i = ~mclk_i;
	pmi_pins #(.DEB_COUNT(2)) dut (.mclk_i, .rst_n_i, .psel_i(ps), .penable_i(pe), .pwrite_i(pw), .paddr_i(pa),
		.pwdata_i(wd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(er), .act_sby_pin_i(ap), .bl_susp_pin_i(bp),
		.feature_connector_strap_bit_i(1'b0), .in_standby_i(sb), .in_suspend_i(su), .standby_timer_restart_o(srr),
		.backlight_timer_restart_o(brr), .standby_request_o(sq), .backlight_off_o(blo), .suspend_request_o(suq),
		.standby_status_n_o(sbn), .suspend_status_n_o(sun));
	pmi_sys_model sys (.mclk_i, .act_req_i(ar), .bl_req_i(br), .act_pin_o(ap), .bl_pin_o(bp));
	// Pulse counters
	always @(posedge mclk_i) begin
		sr_n += srr;
		br_n += brr;
		sq_n += sq;
	end
	task chk(input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		ps <= 1; pw <= w; pa <= a; wd <= d;
		@(posedge mclk_i) pe <= 1;
		for (i = 0; i < 9; i++) begin
			@(posedge mclk_i);
			if (rdy === 1'b1) break;
		end
		if (i == 9) begin chk(0, 1); end_of_test; end
		rd = prd; re = er; ps <= 0; pe <= 0;
		@(posedge mclk_i);
	endtask : apb
	task pulse(input logic [31:0] c);
		apb(1, 8'h00, c);
		ar <= 1; repeat (6) @(posedge mclk_i);
		ar <= 0; repeat (6) @(posedge mclk_i);
	endtask : pulse
	task t_regs;
		apb(0, 8'h00, 0); chk(rd, 0);
		apb(1, 8'h00, 32'h3f); apb(0, 8'h00, 0); chk(rd, 32'h3f);
		apb(0, 8'h10, 0); chk(rd, 0); chk(re, 1);
		$display("regs done");
	endtask : t_regs
	task t_act;
		pulse(32'h35); chk(sr_n, 1); chk(br_n, 1);
		pulse(32'h25); chk(sr_n, 1); chk(br_n, 2);
		pulse(32'h15); chk(sr_n, 2); chk(br_n, 2);
		pulse(32'h37); chk(sr_n, 2); chk(br_n, 2);
		$display("act done");
	endtask : t_act
	task t_sby;
		pulse(32'h01); chk(sq_n, 1); chk(sr_n, 2);
		pulse(32'h03); chk(sq_n, 1);
		$display("sby done");
	endtask : t_sby
	task t_bl;
		apb(1, 8'h00, 32'h08); br <= 1; repeat (3) @(posedge mclk_i);
		chk({blo, suq}, 2);
		apb(0, 8'h04, 0); chk(rd[3], 1);
		apb(1, 8'h00, 0);
		for (i = 0; suq !== 1'b1 && i < 20000; i++) @(posedge mclk_i);
		if (i == 20000) begin chk(0, 1); end_of_test; end
		chk(suq, 1);
		chk(i > 3800 && i < 7640, 1);
		sb <= 1; su <= 1; repeat (2) @(posedge mclk_i);
		chk({sbn, sun}, 0);
		sb <= 0; su <= 0; br <= 0; repeat (2) @(posedge mclk_i);
		chk({sbn, sun}, 3);
		$display("bl done");
	endtask : t_bl
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1;
		@(posedge mclk_i);
		t_regs;
		t_act;
		t_sby;
		t_bl;
		end_of_test;
	end
endmodule : tb_pmi_pins
